// file: rtl/pstb_bank.sv
// Function
// - Page 00h/01h picks channel; FFh reads A.
// - Temperature byte: bits 7,6 latch; rest zero.
// - Writing one clears flag; zero keeps it.
// - Comm byte, input readings ignore page.
// - Bit 7 latches on unknown command.
// - Bit 6 latches on invalid data.
// - Bit 5 latches on packet check mismatch.
// - Bit 3 memory error; bits 4,2 zero.
// - Bit 1 other comm fault; bit 0 zero.
// - Vendor bit 7 latches power stage fault.
// - Vendor bit 6 latches sense pin open.
// - Vendor bit 5 flags, clamps phase count.
// - Vendor bit 4 holds pre-start sense comparison.
// - Vendor bit 3 latches code reset, page 0.
// - Vendor bit 0 after seven imbalance cycles.
// - Linear word: exponent 15:11, mantissa 10:0.
// - Input voltage refreshed every 1200 us.
// - Input current refreshed every 100 us.
// - Read-only write discarded, flagged, alert raised.
// - Output voltage per page, VID, 1200 us.
// - Page FFh reads output voltage A only.
// - Summary bits only mirror individual bytes.
`timescale 1ns/10ps
module pstb_bank
	import pstb_pkg::*;
#(
	parameter int VIN_CYC = VIN_REFRESH_CYC,
	parameter int IIN_CYC = IIN_REFRESH_CYC,
	parameter int VOUT_CYC = VOUT_REFRESH_CYC,
	parameter int PHW = 4,
	parameter logic [3:0] PHASE_MAX = 4'h6
) (
	// Core clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Link-side command port, on the link clock.
	input wire logic lnk_clk_i,
	input wire logic lnk_rst_i,
	input wire logic lnk_req_i,
	input wire logic lnk_write_i,
	input wire logic [7:0] lnk_code_i,
	input wire logic [15:0] lnk_wdata_i,
	input wire logic lnk_pec_err_i,
	input wire logic lnk_other_err_i,
	output logic lnk_busy_o,
	output logic lnk_done_o,
	output logic [15:0] lnk_rdata_o,
	// Page selector held by the command layer.
	input wire logic [7:0] page_i,
	// Fault pins, one bit per channel (bit 0 channel A); code reset and memory error are single bits.
	input wire logic [1:0] ot_fault_i,
	input wire logic [1:0] ot_warn_i,
	input wire logic [1:0] ps_fault_i,
	input wire logic [1:0] sense_open_i,
	input wire logic [1:0] temp_sense_input_high_i,
	input wire logic [1:0] soft_start_i,
	input wire logic vid_reset_i,
	input wire logic mem_error_i,
	// Phase control and imbalance detector, core clock.
	input wire logic [PHW-1:0] ch_a_phase_req_i,
	input wire logic [PHW-1:0] ch_b_phase_req_i,
	input wire logic imb_tick_i,
	input wire logic [1:0] imb_warn_i,
	output logic [PHW-1:0] ch_a_phase_o,
	output logic [PHW-1:0] ch_b_phase_o,
	// Telemetry sources, core clock.
	input wire logic [4:0] vin_exponent_i,
	input wire logic [10:0] vin_mantissa_i,
	input wire logic [4:0] iin_exponent_i,
	input wire logic [10:0] iin_mantissa_i,
	input wire logic [15:0] vout_a_vid_i,
	input wire logic [15:0] vout_b_vid_i,
	// Alert to the host.
	output logic host_alert_out_o
);

	// ------------------------------------------------------------
	// Link domain: capture and hand over a request
	// ------------------------------------------------------------
	logic lnk_req_tgl_r;
	logic lnk_write_r;
	logic [7:0] lnk_code_r;
	logic [15:0] lnk_wdata_r;
	logic lnk_pec_r;
	logic lnk_other_r;
	logic lnk_seen_r;
	logic lnk_resp_f;
	logic lnk_take;
	logic lnk_resp_ev;
	logic resp_tgl_r;
	logic [15:0] resp_data_r;

	// A request during a pending one is dropped; busy tells the front end.
	assign lnk_take = lnk_req_i & ~lnk_busy_o;
	assign lnk_resp_ev = lnk_resp_f ^ lnk_seen_r;

	// Payload stays frozen until the answer returns, so the core may read it.
	always_ff @(posedge lnk_clk_i)
	begin
		if (lnk_rst_i)
		begin
			lnk_req_tgl_r <= 1'b0;
			lnk_write_r <= 1'b0;
			lnk_code_r <= 8'h00;
			lnk_wdata_r <= 16'h0000;
			lnk_pec_r <= 1'b0;
			lnk_other_r <= 1'b0;
			lnk_busy_o <= 1'b0;
		end
		else if (lnk_take)
		begin
			lnk_req_tgl_r <= ~lnk_req_tgl_r;
			lnk_write_r <= lnk_write_i;
			lnk_code_r <= lnk_code_i;
			lnk_wdata_r <= lnk_wdata_i;
			lnk_pec_r <= lnk_pec_err_i;
			lnk_other_r <= lnk_other_err_i;
			lnk_busy_o <= 1'b1;
		end
		else if (lnk_resp_ev)
			lnk_busy_o <= 1'b0;
	end

	// The answer word is stable in the core once its toggle is seen here.
	always_ff @(posedge lnk_clk_i)
	begin
		if (lnk_rst_i)
		begin
			lnk_seen_r <= 1'b0;
			lnk_done_o <= 1'b0;
			lnk_rdata_o <= 16'h0000;
		end
		else
		begin
			lnk_seen_r <= lnk_resp_f;
			lnk_done_o <= lnk_resp_ev;
			if (lnk_resp_ev)
				lnk_rdata_o <= resp_data_r;
		end
	end

	pstb_sync #(.W(1)) u_resp_sync (
		.clk_i(lnk_clk_i),
		.rst_i(lnk_rst_i),
		.ce_i(1'b1),
		.d_i(resp_tgl_r),
		.q_o(lnk_resp_f)
	);

	// ------------------------------------------------------------
	// Core domain: synchronisers
	// ------------------------------------------------------------
	logic req_f;
	logic [13:0] pins_f;
	logic [1:0] ot_fault_f;
	logic [1:0] ot_warn_f;
	logic [1:0] ps_fault_f;
	logic [1:0] sense_open_f;
	logic [1:0] temp_sense_input_high_f;
	logic [1:0] soft_start_f;
	logic vid_reset_f;
	logic mem_error_f;

	pstb_sync #(.W(1)) u_req_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(lnk_req_tgl_r),
		.q_o(req_f)
	);

	pstb_sync #(.W(14)) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({ot_fault_i, ot_warn_i, ps_fault_i, sense_open_i,
			temp_sense_input_high_i, soft_start_i, vid_reset_i, mem_error_i}),
		.q_o(pins_f)
	);

	assign {ot_fault_f, ot_warn_f, ps_fault_f, sense_open_f,
		temp_sense_input_high_f, soft_start_f, vid_reset_f, mem_error_f} = pins_f;

	// ------------------------------------------------------------
	// Telemetry refresh
	// ------------------------------------------------------------
	logic [15:0] vin_r;
	logic [15:0] iin_r;
	logic [15:0] vout_a_r;
	logic [15:0] vout_b_r;

	pstb_refresh #(.W(16), .PERIOD(VIN_CYC)) u_vin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({vin_exponent_i, vin_mantissa_i}),
		.q_o(vin_r)
	);

	pstb_refresh #(.W(16), .PERIOD(IIN_CYC)) u_iin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({iin_exponent_i, iin_mantissa_i}),
		.q_o(iin_r)
	);

	pstb_refresh #(.W(16), .PERIOD(VOUT_CYC)) u_vout_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(vout_a_vid_i),
		.q_o(vout_a_r)
	);

	pstb_refresh #(.W(16), .PERIOD(VOUT_CYC)) u_vout_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(vout_b_vid_i),
		.q_o(vout_b_r)
	);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	pstb_state_e state_r;
	logic req_seen_r;
	logic req_ev;
	logic exec;
	logic hit_temp;
	logic hit_cml;
	logic hit_vnd;
	logic hit_vin;
	logic hit_iin;
	logic hit_vout;
	logic known;
	logic paged;
	logic page_ok;
	logic sel_b;
	logic pec_bad;
	logic cmd_bad;
	logic ro_write;
	logic page_bad;
	logic pay_bad;
	logic wr_ok;
	logic misc_ev;
	logic [1:0] ch_wr;
	logic [7:0] clr_cml;

	assign req_ev = req_f ^ req_seen_r;
	assign exec = (state_r == ST_EXEC);
	assign hit_temp = (lnk_code_r == CMD_TEMP_STATUS);
	assign hit_cml = (lnk_code_r == CMD_CML_STATUS);
	assign hit_vnd = (lnk_code_r == CMD_VENDOR_STATUS);
	assign hit_vin = (lnk_code_r == CMD_VIN);
	assign hit_iin = (lnk_code_r == CMD_IIN);
	assign hit_vout = (lnk_code_r == CMD_VOUT);
	assign known = hit_temp | hit_cml | hit_vnd | hit_vin | hit_iin | hit_vout;
	// Shared commands skip the page check.
	assign paged = hit_temp | hit_vnd | hit_vout;
	assign page_ok = (page_i == PAGE_CH_A) | (page_i == PAGE_CH_B) | (page_i == PAGE_ALL);
	assign sel_b = (page_i == PAGE_CH_B);
	assign pec_bad = exec & lnk_pec_r;
	assign cmd_bad = exec & ~lnk_pec_r & ~known;
	assign ro_write = exec & ~lnk_pec_r & lnk_write_r & (hit_vin | hit_iin | hit_vout);
	assign page_bad = exec & ~lnk_pec_r & paged & ~page_ok;
	assign pay_bad = ro_write | page_bad;
	assign wr_ok = exec & ~lnk_pec_r & lnk_write_r & (page_ok | ~paged);
	assign misc_ev = exec & lnk_other_r;
	// Page FFh writes reach both channels.
	assign ch_wr[0] = wr_ok & (page_i != PAGE_CH_B);
	assign ch_wr[1] = wr_ok & (page_i != PAGE_CH_A);
	assign clr_cml = (wr_ok & hit_cml) ? lnk_wdata_r[7:0] : 8'h00;

	// Sequence: wait for a request, apply it, then send the answer back.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_IDLE;
			req_seen_r <= 1'b0;
			resp_tgl_r <= 1'b0;
		end
		else if (ce_i)
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					if (req_ev)
					begin
						req_seen_r <= req_f;
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: state_r <= ST_DONE;
				ST_DONE:
				begin
					resp_tgl_r <= ~resp_tgl_r;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	logic [7:0] temp_r [2];
	logic [7:0] vnd_r [2];
	logic [7:0] cml_r;
	logic [7:0] cml_set;
	logic [2:0] imb_cnt_r [2];
	logic [PHW-1:0] phase_r [2];
	logic [PHW-1:0] phase_req [2];

	assign phase_req[0] = ch_a_phase_req_i;
	assign phase_req[1] = ch_b_phase_req_i;

	assign cml_set = {cmd_bad, pay_bad, pec_bad, 1'b0, mem_error_f, 1'b0, misc_ev, 1'b0};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cml_r <= STATUS_RESET;
		else if (ce_i)
			cml_r <= ((cml_r & ~clr_cml) | cml_set) & CML_STATUS_MASK;
	end

	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		logic [7:0] temp_set;
		logic [7:0] vnd_set;
		logic [7:0] clr_temp;
		logic [7:0] clr_vnd;
		logic clamp_ev;
		logic imb_ev;
		logic tsns_ev;
		logic vid_ev;

		assign clamp_ev = (phase_req[c] > PHASE_MAX);
		assign imb_ev = imb_tick_i & imb_warn_i[c] & (imb_cnt_r[c] >= IMBALANCE_CYCLES - 3'h1);
		assign tsns_ev = temp_sense_input_high_f[c] & ~soft_start_f[c];
		// Code reset counted on page 0 only.
		assign vid_ev = (c == 0) ? vid_reset_f : 1'b0;
		assign temp_set = {ot_fault_f[c], ot_warn_f[c], 6'h00};
		assign vnd_set = {ps_fault_f[c], sense_open_f[c], clamp_ev, tsns_ev, vid_ev, 2'b00, imb_ev};
		assign clr_temp = (ch_wr[c] & hit_temp) ? lnk_wdata_r[7:0] : 8'h00;
		assign clr_vnd = (ch_wr[c] & hit_vnd) ? lnk_wdata_r[7:0] : 8'h00;

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				temp_r[c] <= STATUS_RESET;
				vnd_r[c] <= STATUS_RESET;
			end
			else if (ce_i)
			begin
				temp_r[c] <= ((temp_r[c] & ~clr_temp) | temp_set) & TEMP_STATUS_MASK;
				vnd_r[c] <= ((vnd_r[c] & ~clr_vnd) | vnd_set) & VENDOR_STATUS_MASK;
			end
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				imb_cnt_r[c] <= 3'h0;
			else if (ce_i & imb_tick_i)
				imb_cnt_r[c] <= ~imb_warn_i[c] ? 3'h0 :
					(imb_cnt_r[c] == IMBALANCE_CYCLES) ? imb_cnt_r[c] : imb_cnt_r[c] + 3'h1;
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				phase_r[c] <= '0;
			else if (ce_i)
				phase_r[c] <= clamp_ev ? PHASE_MAX : phase_req[c];
		end
	end

	assign ch_a_phase_o = phase_r[0];
	assign ch_b_phase_o = phase_r[1];

	// ------------------------------------------------------------
	// Read data and alert
	// ------------------------------------------------------------
	logic [15:0] rd_word;
	logic [15:0] rd_paged;

	// Channel B only on page 01h; FFh reads A.
	assign rd_paged = hit_temp ? {8'h00, temp_r[sel_b]} :
		hit_vnd ? {8'h00, vnd_r[sel_b]} :
		sel_b ? vout_b_r : vout_a_r;
	assign rd_word = (lnk_write_r | lnk_pec_r | ~known) ? READING_RESET :
		hit_cml ? {8'h00, cml_r} :
		hit_vin ? vin_r :
		hit_iin ? iin_r :
		page_ok ? rd_paged : READING_RESET;

	// Read values are taken before this request's own clear lands.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			resp_data_r <= READING_RESET;
		else if (ce_i & exec)
			resp_data_r <= rd_word;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			host_alert_out_o <= 1'b0;
		else if (ce_i)
			host_alert_out_o <= (|cml_r) | (|temp_r[0]) | (|temp_r[1]) |
				(|vnd_r[0]) | (|vnd_r[1]);
	end

endmodule : pstb_bank

// file: rtl/pstb_pkg.sv
package pstb_pkg;

	// ------------------------------------------------------------
	// Command codes and page selector values
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
	localparam logic [7:0] CMD_CML_STATUS = 8'h7e;
	localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
	localparam logic [7:0] CMD_VIN = 8'h88;
	localparam logic [7:0] CMD_IIN = 8'h89;
	localparam logic [7:0] CMD_VOUT = 8'h8b;
	localparam logic [7:0] PAGE_CH_A = 8'h00;
	localparam logic [7:0] PAGE_CH_B = 8'h01;
	localparam logic [7:0] PAGE_ALL = 8'hff;

	// ------------------------------------------------------------
	// Field positions inside the status bytes
	// ------------------------------------------------------------
	localparam int OVER_TEMP_FAULT_FLAG_BIT = 7;
	localparam int OVER_TEMP_WARNING_FLAG_BIT = 6;
	localparam int BAD_COMMAND_FLAG_BIT = 7;
	localparam int BAD_PAYLOAD_FLAG_BIT = 6;
	localparam int PACKET_CHECK_ERROR_FLAG_BIT = 5;
	localparam int MEMORY_ERROR_FLAG_BIT = 3;
	localparam int MISC_LOGIC_FLAG_BIT = 1;
	localparam int POWER_STAGE_FAULT_FLAG_BIT = 7;
	localparam int SENSE_OPEN_FLAG_BIT = 6;
	localparam int PHASE_COUNT_CLAMP_FLAG_BIT = 5;
	localparam int TEMP_SENSE_LEVEL_FLAG_BIT = 4;
	localparam int VOLTAGE_CODE_RESET_FLAG_BIT = 3;
	localparam int PHASE_SHARE_FAULT_FLAG_BIT = 0;

	// Bits that can ever read as one; all others read zero.
	localparam logic [7:0] TEMP_STATUS_MASK = 8'hc0;
	localparam logic [7:0] CML_STATUS_MASK = 8'hea;
	localparam logic [7:0] VENDOR_STATUS_MASK = 8'hf9;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] READING_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int VIN_REFRESH_US = 1200;
	localparam int IIN_REFRESH_US = 100;
	localparam int VOUT_REFRESH_US = 1200;
	localparam int VIN_REFRESH_CYC = VIN_REFRESH_US * CLK_MHZ;
	localparam int IIN_REFRESH_CYC = IIN_REFRESH_US * CLK_MHZ;
	localparam int VOUT_REFRESH_CYC = VOUT_REFRESH_US * CLK_MHZ;
	localparam logic [2:0] IMBALANCE_CYCLES = 3'h7;

	// ------------------------------------------------------------
	// Command engine states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_DONE = 3'b100
	} pstb_state_e;

endpackage : pstb_pkg

// file: rtl/pstb_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; a change is passed on once stages two and three agree.
module pstb_sync #(
	parameter int W = 1
) (
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Asynchronous levels in, filtered levels out.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;

	// Only bits whose last two stages agree may move the output.
	assign q_nxt = (s3_r & ~(s2_r ^ s3_r)) | (q_o & (s2_r ^ s3_r));

	// Shift chain and filtered output.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_o <= '0;
		end
		else if (ce_i)
		begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_o <= q_nxt;
		end
	end

endmodule : pstb_sync

// file: rtl/pstb_refresh.sv
`timescale 1ns/10ps
// Periodic sampler: the reading is refreshed once every PERIOD cycles.
module pstb_refresh #(
	parameter int W = 16,
	parameter int PERIOD = 5000
) (
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Live value in, held reading out.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	localparam int CW = $clog2(PERIOD + 1);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	logic [CW-1:0] cnt_r;
	logic wrap;

	assign wrap = (cnt_r == LAST);

	// Holding the sample between refreshes keeps a word read coherent.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r <= '0;
			q_o <= '0;
		end
		else if (ce_i)
		begin
			cnt_r <= wrap ? '0 : cnt_r + 1'b1;
			if (wrap)
				q_o <= d_i;
		end
	end

endmodule : pstb_refresh

// file: verification/pstb_bank_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the status and telemetry bank
// ------------------------------------------------------------
module pstb_bank_props #(
	parameter int PHW = 4,
	parameter logic [3:0] PHASE_MAX = 4'h6
) (
	// Core domain.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [PHW-1:0] ch_a_phase_req_i,
	input wire logic [PHW-1:0] ch_b_phase_req_i,
	input wire logic [PHW-1:0] ch_a_phase_o,
	input wire logic [PHW-1:0] ch_b_phase_o,
	// Link domain.
	input wire logic lnk_clk_i,
	input wire logic lnk_rst_i,
	input wire logic lnk_req_i,
	input wire logic [7:0] lnk_code_i,
	input wire logic lnk_busy_o,
	input wire logic lnk_done_o,
	input wire logic [15:0] lnk_rdata_o
);
	logic [7:0] code_r;

	// The answer carries no code, so the taken command is kept to judge it.
	always_ff @(posedge lnk_clk_i)
	begin
		if (lnk_rst_i)
			code_r <= 8'h00;
		else if (lnk_req_i && !lnk_busy_o)
			code_r <= lnk_code_i;
	end

	AST_DONE_PULSE: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		lnk_done_o |=> !lnk_done_o) else $error("done stood longer than one cycle");
	AST_DONE_FREE: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		lnk_done_o |-> !lnk_busy_o) else $error("busy still high with done");
	AST_TAKE: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		lnk_req_i && !lnk_busy_o |=> lnk_busy_o) else $error("request not taken");
	AST_ANSWER: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		$rose(lnk_busy_o) |-> ##[1:20] lnk_done_o) else $error("no answer in time");
	AST_RDATA_HOLD: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		!$stable(lnk_rdata_o) |-> lnk_done_o) else $error("read data moved without done");
	AST_TEMP_RSV: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		lnk_done_o && code_r == 8'h7d |-> (lnk_rdata_o & 16'hff3f) == 16'h0000)
		else $error("temperature byte reserved bits set");
	AST_CML_RSV: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		lnk_done_o && code_r == 8'h7e |-> (lnk_rdata_o & 16'hff15) == 16'h0000)
		else $error("comm byte reserved bits set");
	AST_VENDOR_RSV: assert property (@(posedge lnk_clk_i) disable iff (lnk_rst_i)
		lnk_done_o && code_r == 8'h80 |-> (lnk_rdata_o & 16'hff06) == 16'h0000)
		else $error("vendor byte reserved bits set");
	AST_CLAMP_HI: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ch_a_phase_req_i > PHASE_MAX |=> ch_a_phase_o == PHASE_MAX)
		else $error("phase count not clamped");
	AST_CLAMP_LO: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ch_b_phase_req_i <= PHASE_MAX |=> ch_b_phase_o == $past(ch_b_phase_req_i))
		else $error("legal phase count altered");
endmodule : pstb_bank_props

// file: verification/pstb_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host side of the link: one transfer at a time
// ------------------------------------------------------------
module pstb_host_model (
	// Link clock and answer.
	input wire logic lnk_clk_i,
	input wire logic lnk_done_i,
	input wire logic [15:0] lnk_rdata_i,
	// Request.
	output logic lnk_req_o,
	output logic lnk_write_o,
	output logic [7:0] lnk_code_o,
	output logic [15:0] lnk_wdata_o,
	output logic lnk_pec_err_o,
	output logic lnk_other_err_o
);
	// Idle request lines from time zero.
	initial
	begin
		lnk_req_o = 1'b0;
		lnk_write_o = 1'b0;
		lnk_code_o = 8'h00;
		lnk_wdata_o = 16'h0000;
		lnk_pec_err_o = 1'b0;
		lnk_other_err_o = 1'b0;
	end

	// byte and word transfers
	// Byte data ride in the low byte; the answer is taken in the cycle done stands.
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] d,
		input logic pec, input logic oth, output logic [15:0] rd);
		int n;
		rd = 'x;
		@(posedge lnk_clk_i);
		#1;
		lnk_req_o = 1'b1;
		lnk_write_o = wr;
		lnk_code_o = code;
		lnk_wdata_o = d;
		lnk_pec_err_o = pec;
		lnk_other_err_o = oth;
		@(posedge lnk_clk_i);
		#1;
		// Released lines except write show the inverse, so a late sample cannot match by luck.
		lnk_req_o = 1'b0;
		lnk_code_o = ~code;
		lnk_wdata_o = ~d;
		lnk_pec_err_o = ~pec;
		lnk_other_err_o = ~oth;
		for (n = 0; n < 40; n++)
		begin
			if (lnk_done_i === 1'b1)
			begin
				rd = lnk_rdata_i;
				n = 40;
			end
			else
			begin
				@(posedge lnk_clk_i);
				#1;
			end
		end
	endtask : xfer
endmodule : pstb_host_model

// file: verification/pmbus_status_telemetry_bank_tb.sv
`timescale 1ns/10ps
module pmbus_status_telemetry_bank_tb;
	import pstb_pkg::*;
	logic clk_i, rst_i, ce_i, lnk_clk_i, lnk_rst_i, lnk_req_i, lnk_write_i;
	logic lnk_pec_err_i, lnk_other_err_i, lnk_busy_o, lnk_done_o, host_alert_out_o;
	logic vid_reset_i, mem_error_i, imb_tick_i;
	logic [7:0] lnk_code_i, page_i;
	logic [15:0] lnk_wdata_i, lnk_rdata_o, vout_a_vid_i, vout_b_vid_i, rdata;
	logic [1:0] ot_fault_i, ot_warn_i, ps_fault_i, sense_open_i, soft_start_i, imb_warn_i;
	logic [1:0] temp_sense_input_high_i;
	logic [3:0] ch_a_phase_req_i, ch_b_phase_req_i, ch_a_phase_o, ch_b_phase_o;
	logic [4:0] vin_exponent_i, iin_exponent_i;
	logic [10:0] vin_mantissa_i, iin_mantissa_i;
	logic [7:0] ro [3] = '{CMD_VIN, CMD_IIN, CMD_VOUT};
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	// Short refresh periods keep the run brief.
	pstb_bank #(.VIN_CYC(20), .IIN_CYC(10), .VOUT_CYC(20)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .lnk_clk_i(lnk_clk_i),
		.lnk_rst_i(lnk_rst_i), .lnk_req_i(lnk_req_i), .lnk_write_i(lnk_write_i),
		.lnk_code_i(lnk_code_i), .lnk_wdata_i(lnk_wdata_i), .lnk_pec_err_i(lnk_pec_err_i),
		.lnk_other_err_i(lnk_other_err_i), .lnk_busy_o(lnk_busy_o), .lnk_done_o(lnk_done_o),
		.lnk_rdata_o(lnk_rdata_o), .page_i(page_i), .ot_fault_i(ot_fault_i),
		.ot_warn_i(ot_warn_i), .ps_fault_i(ps_fault_i), .sense_open_i(sense_open_i),
		.temp_sense_input_high_i(temp_sense_input_high_i), .soft_start_i(soft_start_i),
		.vid_reset_i(vid_reset_i), .mem_error_i(mem_error_i),
		.ch_a_phase_req_i(ch_a_phase_req_i), .ch_b_phase_req_i(ch_b_phase_req_i),
		.imb_tick_i(imb_tick_i), .imb_warn_i(imb_warn_i), .ch_a_phase_o(ch_a_phase_o),
		.ch_b_phase_o(ch_b_phase_o), .vin_exponent_i(vin_exponent_i),
		.vin_mantissa_i(vin_mantissa_i), .iin_exponent_i(iin_exponent_i),
		.iin_mantissa_i(iin_mantissa_i), .vout_a_vid_i(vout_a_vid_i),
		.vout_b_vid_i(vout_b_vid_i), .host_alert_out_o(host_alert_out_o));

	pstb_host_model i_host (
		.lnk_clk_i(lnk_clk_i), .lnk_done_i(lnk_done_o), .lnk_rdata_i(lnk_rdata_o),
		.lnk_req_o(lnk_req_i), .lnk_write_o(lnk_write_i), .lnk_code_o(lnk_code_i),
		.lnk_wdata_o(lnk_wdata_i), .lnk_pec_err_o(lnk_pec_err_i),
		.lnk_other_err_o(lnk_other_err_i));

	// Core clock and a link clock of unrelated phase.
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial
	begin
		lnk_clk_i = 1'b0;
		#7;
		forever #62.5 lnk_clk_i = ~lnk_clk_i;
	end

	// A hang ends the run as a failure.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc

	task automatic op(input logic wr, input logic [7:0] code, input logic [15:0] d,
		input logic pec, input logic oth);
		i_host.xfer(wr, code, d, pec, oth, rdata);
	endtask : op

	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		op(1'b0, code, 16'h0000, 1'b0, 1'b0);
		check($sformatf("command %h", code), rdata, exp);
	endtask : rd

	task automatic wr(input logic [7:0] code, input logic [7:0] d);
		op(1'b1, code, {8'h00, d}, 1'b0, 1'b0);
	endtask : wr

	task automatic pg(input logic [7:0] p);
		cyc(1);
		page_i = p;
		cyc(4);
	endtask : pg

	task automatic tick(input int n);
		cyc(1);
		repeat (n)
		begin
			imb_tick_i = 1'b1;
			cyc(1);
			imb_tick_i = 1'b0;
			cyc(1);
		end
	endtask : tick

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst_i, lnk_rst_i, ce_i} = 3'b111;
		{vid_reset_i, mem_error_i, imb_tick_i} = 3'b000;
		{ot_fault_i, ot_warn_i, ps_fault_i, sense_open_i} = 8'h00;
		{soft_start_i, imb_warn_i, temp_sense_input_high_i} = 6'h00;
		{ch_a_phase_req_i, ch_b_phase_req_i, page_i} = 16'h0000;
		{vin_exponent_i, vin_mantissa_i, iin_exponent_i, iin_mantissa_i} = 32'h0;
		{vout_a_vid_i, vout_b_vid_i} = 32'h0;
		cyc(6);
		rst_i = 1'b0;
		repeat (2) @(posedge lnk_clk_i);
		#1;
		lnk_rst_i = 1'b0;
		// Temperature flags latch per channel and clear by writing ones.
		cyc(4);
		ot_fault_i = 2'b10;
		ot_warn_i = 2'b01;
		cyc(12);
		{ot_fault_i, ot_warn_i} = 4'h0;
		cyc(12);
		rd(CMD_TEMP_STATUS, 16'h0040);
		pg(PAGE_CH_B);
		rd(CMD_TEMP_STATUS, 16'h0080);
		pg(PAGE_ALL);
		rd(CMD_TEMP_STATUS, 16'h0040);
		wr(CMD_TEMP_STATUS, 8'h00);
		rd(CMD_TEMP_STATUS, 16'h0040);
		wr(CMD_TEMP_STATUS, 8'hc0);
		rd(CMD_TEMP_STATUS, 16'h0000);
		pg(PAGE_CH_B);
		rd(CMD_TEMP_STATUS, 16'h0000);
		// Communication faults, shared, seen from page B.
		rd(8'h55, 16'h0000);
		rd(CMD_CML_STATUS, 16'h0080);
		wr(CMD_CML_STATUS, 8'hff);
		op(1'b1, CMD_CML_STATUS, 16'h00ff, 1'b1, 1'b0);
		rd(CMD_CML_STATUS, 16'h0020);
		wr(CMD_CML_STATUS, 8'hff);
		op(1'b0, CMD_VIN, 16'h0000, 1'b0, 1'b1);
		rd(CMD_CML_STATUS, 16'h0002);
		wr(CMD_CML_STATUS, 8'hff);
		foreach (ro[i])
		begin
			op(1'b1, ro[i], 16'h1234, 1'b0, 1'b0);
			rd(CMD_CML_STATUS, 16'h0040);
			check("alert", {15'h0000, host_alert_out_o}, 16'h0001);
			wr(CMD_CML_STATUS, 8'hff);
		end
		cyc(1);
		mem_error_i = 1'b1;
		cyc(12);
		mem_error_i = 1'b0;
		cyc(12);
		rd(CMD_CML_STATUS, 16'h0008);
		wr(CMD_CML_STATUS, 8'hff);
		rd(CMD_CML_STATUS, 16'h0000);
		// Telemetry words.
		cyc(1);
		{vin_exponent_i, vin_mantissa_i} = {5'h1e, 11'h123};
		{iin_exponent_i, iin_mantissa_i} = {5'h02, 11'h456};
		{vout_a_vid_i, vout_b_vid_i} = {16'h00a5, 16'h005a};
		cyc(40);
		rd(CMD_VIN, {5'h1e, 11'h123});
		rd(CMD_IIN, {5'h02, 11'h456});
		rd(CMD_VOUT, 16'h005a);
		pg(PAGE_ALL);
		rd(CMD_VOUT, 16'h00a5);
		rd(CMD_VIN, {5'h1e, 11'h123});
		// Vendor flags on channel A.
		pg(PAGE_CH_A);
		imb_warn_i = 2'b01;
		tick(6);
		rd(CMD_VENDOR_STATUS, 16'h0000);
		tick(1);
		rd(CMD_VENDOR_STATUS, 16'h0001);
		cyc(1);
		imb_warn_i = 2'b00;
		wr(CMD_VENDOR_STATUS, 8'hff);
		// The sense comparison only counts while soft-start is low.
		{soft_start_i, temp_sense_input_high_i} = 4'b0101;
		cyc(12);
		{soft_start_i, temp_sense_input_high_i} = 4'h0;
		cyc(12);
		rd(CMD_VENDOR_STATUS, 16'h0000);
		cyc(1);
		{ps_fault_i, sense_open_i, temp_sense_input_high_i} = 6'b010101;
		{vid_reset_i, ch_a_phase_req_i, ch_b_phase_req_i} = {1'b1, 4'h9, 4'h3};
		cyc(12);
		check("phase a", {12'h000, ch_a_phase_o}, 16'h0006);
		check("phase b", {12'h000, ch_b_phase_o}, 16'h0003);
		{ps_fault_i, sense_open_i, temp_sense_input_high_i, vid_reset_i} = 7'h00;
		ch_a_phase_req_i = 4'h2;
		cyc(12);
		rd(CMD_VENDOR_STATUS, 16'h00f8);
		pg(PAGE_CH_B);
		rd(CMD_VENDOR_STATUS, 16'h0000);
		pg(PAGE_CH_A);
		wr(CMD_VENDOR_STATUS, 8'hff);
		rd(CMD_VENDOR_STATUS, 16'h0000);
		// A frozen core must miss a pin pulse entirely.
		ce_i = 1'b0;
		mem_error_i = 1'b1;
		cyc(12);
		mem_error_i = 1'b0;
		cyc(12);
		ce_i = 1'b1;
		rd(CMD_CML_STATUS, 16'h0000);
		check("alert", {15'h0000, host_alert_out_o}, 16'h0000);
		wrap_up();
	end
endmodule : pmbus_status_telemetry_bank_tb

bind pstb_bank pstb_bank_props #(.PHW(PHW), .PHASE_MAX(PHASE_MAX)) i_props (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ch_a_phase_req_i(ch_a_phase_req_i),
	.ch_b_phase_req_i(ch_b_phase_req_i), .ch_a_phase_o(ch_a_phase_o),
	.ch_b_phase_o(ch_b_phase_o), .lnk_clk_i(lnk_clk_i), .lnk_rst_i(lnk_rst_i),
	.lnk_req_i(lnk_req_i), .lnk_code_i(lnk_code_i), .lnk_busy_o(lnk_busy_o),
	.lnk_done_o(lnk_done_o), .lnk_rdata_o(lnk_rdata_o));
